// ### verilog/aalm_regs.svh
`ifndef AALM_REGS_SVH
`define AALM_REGS_SVH

// register map seen over apb: one aligned word per entry, data in bits 7:0
`define AALM_GPR_BASE 8'h00
`define AALM_GPR_LAST 8'h7C
`define AALM_STATUS_OFS 8'h80

// status flag positions
`define AALM_FLAG_C 0
`define AALM_FLAG_Z 1
`define AALM_FLAG_N 2
`define AALM_FLAG_V 3
`define AALM_FLAG_S 4
`define AALM_FLAG_H 5

// flag groups touched by each instruction class
`define AALM_MASK_ZCNVH 8'h2F
`define AALM_MASK_ZCNV 8'h0F
`define AALM_MASK_ZNV 8'h0E
`define AALM_MASK_ZCNVS 8'h1F
`define AALM_MASK_ZC 8'h03
`define AALM_MASK_NONE 8'h00

// reset values
`define AALM_STATUS_RST 8'h00
`define AALM_GPR_RST 8'h00

// fixed operand places
`define AALM_PAIR_HI_OFS 5'h01
`define AALM_PROD_LO_IDX 5'h00
`define AALM_PROD_HI_IDX 5'h01
`define AALM_ALL_ONES 8'hFF
`define AALM_ONE 8'h01

`endif

// ### verilog/aalm_pkg.sv
package aalm_pkg;

  typedef enum logic [4:0] {
    OP_NONE = 5'h00,
    OP_ADD = 5'h01,
    OP_ADD_CARRY = 5'h02,
    OP_SUB = 5'h03,
    OP_DIFFERENCE_WITH_BORROW = 5'h04,
    OP_MINUS_CONSTANT = 5'h05,
    OP_MINUS_CONSTANT_WITH_BORROW = 5'h06,
    OP_WORD_PLUS_IMMEDIATE = 5'h07,
    OP_WORD_MINUS_IMMEDIATE = 5'h08,
    OP_AND = 5'h09,
    OP_CONJUNCTION_WITH_CONSTANT = 5'h0A,
    OP_OR = 5'h0B,
    OP_DISJUNCTION_WITH_CONSTANT = 5'h0C,
    OP_BITWISE_EXCLUSIVE_DISJUNCTION = 5'h0D,
    OP_ONES_INVERT = 5'h0E,
    OP_TWOS_INVERT = 5'h0F,
    OP_MASK_SET_BITS = 5'h10,
    OP_MASK_CLEAR_BITS = 5'h11,
    OP_PLUS_ONE = 5'h12,
    OP_MINUS_ONE = 5'h13,
    OP_ZERO_SIGN_CHECK = 5'h14,
    OP_ZERO_REGISTER = 5'h15,
    OP_ALL_ONES_REGISTER = 5'h16,
    OP_UNSIGNED_PRODUCT = 5'h17,
    OP_SIGNED_PRODUCT = 5'h18,
    OP_MIXED_SIGN_PRODUCT = 5'h19,
    OP_FRACTIONAL_UNSIGNED_PRODUCT = 5'h1A,
    OP_FRACTIONAL_SIGNED_PRODUCT = 5'h1B,
    OP_FRACTIONAL_MIXED_PRODUCT = 5'h1C
  } aalm_op_type;

  typedef struct packed {
    aalm_op_type op;
    logic [4:0] rd;
    logic [4:0] source_register;
    logic [7:0] imm;
  } aalm_cmd_type;

  typedef struct packed {
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } aalm_apb_req_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SECOND = 2'b10
  } aalm_state_type;

endpackage

// ### verilog/aalm_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "aalm_regs.svh"
// Behaviour
// (RQ1) register add, optional carry, ZCNVH, one cycle
// (RQ2) register subtract, optional borrow, ZCNVH, one cycle
// (RQ3) subtract constant from destination, ZCNVH, one cycle
// (RQ4) subtract constant and carry, ZCNVH, one cycle
// (RQ5) word plus immediate on pair, ZCNVS, two cycles
// (RQ6) word minus immediate on pair, ZCNVS, two cycles
// (RQ7) and with register or constant, ZNV
// (RQ8) or, constant or, xor: ZNV, one cycle
// (RQ9) set bits ors mask in, ZNV
// (RQ10) clear bits ands with inverted mask, ZNV
// (RQ11) test ands register with itself, ZNV
// (RQ12) three 8x8 multiplies into pair 1:0, ZC
// (RQ13) fractional multiplies shift product left once
// (RQ14) ones invert ZCNV, twos invert ZCNVH
// (RQ15) inc, dec, clear ZNV; set all ones: no flags
// (RQ16) unlisted flags keep their previous values

module aalm_core
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic cmd_valid_i,
  input wire aalm_pkg::aalm_cmd_type cmd_i,
  input wire aalm_pkg::aalm_apb_req_type apb_i,
  output logic busy_o,
  output logic done_o,
  output logic [7:0] status_o,
  output logic apb_pready_o,
  output logic [31:0] apb_prdata_o,
  output logic apb_pslverr_o
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------

  // returns {h, c, v, result}
  function automatic logic [10:0] f_add(input logic [7:0] x, input logic [7:0] y,
                                        input logic ci);
    logic [8:0] s;
    logic [4:0] l;
    s = {1'b0, x} + {1'b0, y} + {8'h00, ci};
    l = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
    f_add = {l[4], s[8], (x[7] & y[7] & ~s[7]) | (~x[7] & ~y[7] & s[7]), s[7:0]};
  endfunction

  // returns {h, c, v, result}; c and h are borrows
  function automatic logic [10:0] f_sub(input logic [7:0] x, input logic [7:0] y,
                                        input logic ci);
    logic [8:0] d;
    logic [4:0] l;
    d = {1'b0, x} - {1'b0, y} - {8'h00, ci};
    l = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, ci};
    f_sub = {l[4], d[8], (x[7] & ~y[7] & ~d[7]) | (~x[7] & y[7] & d[7]), d[7:0]};
  endfunction

  // z, c, n, v, h from an arithmetic result
  function automatic logic [7:0] f_arith_flags(input logic [10:0] r);
    logic [7:0] f;
    f = 8'h00;
    f[`AALM_FLAG_H] = r[10];
    f[`AALM_FLAG_C] = r[9];
    f[`AALM_FLAG_V] = r[8];
    f[`AALM_FLAG_N] = r[7];
    f[`AALM_FLAG_Z] = (r[7:0] == 8'h00);
    f_arith_flags = f;
  endfunction

  // z and n from a result, v cleared
  function automatic logic [7:0] f_logic_flags(input logic [7:0] r);
    logic [7:0] f;
    f = 8'h00;
    f[`AALM_FLAG_N] = r[7];
    f[`AALM_FLAG_Z] = (r == 8'h00);
    f_logic_flags = f;
  endfunction

  function automatic logic [7:0] f_merge(input logic [7:0] old_f, input logic [7:0] new_f,
                                         input logic [7:0] mask);
    f_merge = (old_f & ~mask) | (new_f & mask); // RQ16
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------

  logic [7:0] gpr [32];
  logic [7:0] sreg;
  aalm_pkg::aalm_state_type state;
  logic [15:0] hold_res;
  logic [7:0] hold_flags;
  logic [7:0] hold_mask;
  logic [4:0] hold_lo;
  logic [4:0] hold_hi;

  // ---------------------------------------------------------------
  // operand fetch and decode
  // ---------------------------------------------------------------

  wire logic [4:0] pair_hi_idx = cmd_i.rd + `AALM_PAIR_HI_OFS;
  wire logic [7:0] op_a = gpr[cmd_i.rd];
  wire logic [7:0] op_b = gpr[cmd_i.source_register];
  wire logic [7:0] op_k = cmd_i.imm;
  wire logic carry_in = sreg[`AALM_FLAG_C];
  wire logic [15:0] pair_val = {gpr[pair_hi_idx], op_a};

  wire logic idle = (state == aalm_pkg::ST_IDLE);
  wire logic cmd_take = cmd_valid_i & idle;
  wire logic commit_long = (state == aalm_pkg::ST_SECOND);

  // multiplier: 9-bit operands so one signed multiplier covers every sign mix
  wire logic mul_a_signed = (cmd_i.op == aalm_pkg::OP_SIGNED_PRODUCT)
                          | (cmd_i.op == aalm_pkg::OP_MIXED_SIGN_PRODUCT)
                          | (cmd_i.op == aalm_pkg::OP_FRACTIONAL_SIGNED_PRODUCT)
                          | (cmd_i.op == aalm_pkg::OP_FRACTIONAL_MIXED_PRODUCT);
  wire logic mul_b_signed = (cmd_i.op == aalm_pkg::OP_SIGNED_PRODUCT)
                          | (cmd_i.op == aalm_pkg::OP_FRACTIONAL_SIGNED_PRODUCT);
  wire logic mul_frac = (cmd_i.op == aalm_pkg::OP_FRACTIONAL_UNSIGNED_PRODUCT)
                      | (cmd_i.op == aalm_pkg::OP_FRACTIONAL_SIGNED_PRODUCT)
                      | (cmd_i.op == aalm_pkg::OP_FRACTIONAL_MIXED_PRODUCT);
  wire logic signed [8:0] mul_a = {mul_a_signed & op_a[7], op_a};
  wire logic signed [8:0] mul_b = {mul_b_signed & op_b[7], op_b};
  wire logic signed [17:0] mul_full = mul_a * mul_b;
  wire logic [15:0] mul_raw = mul_full[15:0];
  // carry is taken from the product before the fractional shift
  wire logic [15:0] mul_res = mul_frac ? {mul_raw[14:0], 1'b0} : mul_raw; // RQ13

  wire logic [15:0] word_sum = pair_val + {8'h00, op_k};
  wire logic [15:0] word_dif = pair_val - {8'h00, op_k};

  // ---------------------------------------------------------------
  // result and flag selection
  // ---------------------------------------------------------------

  logic [10:0] arith;
  logic [7:0] res8;
  logic [7:0] next_flags;
  logic [7:0] flag_mask;
  logic write8;
  logic long_op;
  logic [15:0] res16;
  logic [4:0] long_lo;
  logic [4:0] long_hi;

  always_comb
  begin
    arith = 11'h000;
    res8 = op_a;
    next_flags = 8'h00;
    flag_mask = `AALM_MASK_NONE;
    write8 = 1'b0;
    long_op = 1'b0;
    res16 = 16'h0000;
    long_lo = cmd_i.rd;
    long_hi = pair_hi_idx;
    case (cmd_i.op)
      aalm_pkg::OP_ADD,
      aalm_pkg::OP_ADD_CARRY:
      begin
        arith = f_add(op_a, op_b, (cmd_i.op == aalm_pkg::OP_ADD_CARRY) & carry_in); // RQ1
        flag_mask = `AALM_MASK_ZCNVH;
      end
      aalm_pkg::OP_SUB,
      aalm_pkg::OP_DIFFERENCE_WITH_BORROW:
      begin
        arith = f_sub(op_a, op_b,
                      (cmd_i.op == aalm_pkg::OP_DIFFERENCE_WITH_BORROW) & carry_in); // RQ2
        flag_mask = `AALM_MASK_ZCNVH;
      end
      aalm_pkg::OP_MINUS_CONSTANT:
      begin
        arith = f_sub(op_a, op_k, 1'b0); // RQ3
        flag_mask = `AALM_MASK_ZCNVH;
      end
      aalm_pkg::OP_MINUS_CONSTANT_WITH_BORROW:
      begin
        arith = f_sub(op_a, op_k, carry_in); // RQ4
        flag_mask = `AALM_MASK_ZCNVH;
      end
      aalm_pkg::OP_TWOS_INVERT:
      begin
        arith = f_sub(8'h00, op_a, 1'b0); // RQ14
        flag_mask = `AALM_MASK_ZCNVH;
      end
      aalm_pkg::OP_ONES_INVERT:
      begin
        arith = f_sub(`AALM_ALL_ONES, op_a, 1'b0);
        arith[9] = 1'b1; // RQ14
        arith[8] = 1'b0;
        flag_mask = `AALM_MASK_ZCNV;
      end
      aalm_pkg::OP_PLUS_ONE:
      begin
        arith = f_add(op_a, `AALM_ONE, 1'b0); // RQ15
        flag_mask = `AALM_MASK_ZNV;
      end
      aalm_pkg::OP_MINUS_ONE:
      begin
        arith = f_sub(op_a, `AALM_ONE, 1'b0); // RQ15
        flag_mask = `AALM_MASK_ZNV;
      end
      aalm_pkg::OP_AND,
      aalm_pkg::OP_CONJUNCTION_WITH_CONSTANT,
      aalm_pkg::OP_ZERO_SIGN_CHECK:
      begin
        // a test is an and of the register with itself
        arith[7:0] = op_a & ((cmd_i.op == aalm_pkg::OP_AND) ? op_b
                   : (cmd_i.op == aalm_pkg::OP_ZERO_SIGN_CHECK) ? op_a : op_k); // RQ7 RQ11
        flag_mask = `AALM_MASK_ZNV;
      end
      aalm_pkg::OP_OR,
      aalm_pkg::OP_DISJUNCTION_WITH_CONSTANT,
      aalm_pkg::OP_MASK_SET_BITS:
      begin
        arith[7:0] = op_a | ((cmd_i.op == aalm_pkg::OP_OR) ? op_b : op_k); // RQ8 RQ9
        flag_mask = `AALM_MASK_ZNV;
      end
      aalm_pkg::OP_BITWISE_EXCLUSIVE_DISJUNCTION,
      aalm_pkg::OP_ZERO_REGISTER:
      begin
        arith[7:0] = op_a ^ ((cmd_i.op == aalm_pkg::OP_ZERO_REGISTER) ? op_a : op_b); // RQ8 RQ15
        flag_mask = `AALM_MASK_ZNV;
      end
      aalm_pkg::OP_MASK_CLEAR_BITS:
      begin
        arith[7:0] = op_a & (`AALM_ALL_ONES - op_k); // RQ10
        flag_mask = `AALM_MASK_ZNV;
      end
      aalm_pkg::OP_ALL_ONES_REGISTER:
      begin
        arith[7:0] = `AALM_ALL_ONES; // RQ15
      end
      aalm_pkg::OP_WORD_PLUS_IMMEDIATE:
      begin
        long_op = 1'b1;
        res16 = word_sum; // RQ5
        next_flags[`AALM_FLAG_V] = ~pair_val[15] & word_sum[15];
        next_flags[`AALM_FLAG_C] = pair_val[15] & ~word_sum[15];
        next_flags[`AALM_FLAG_N] = word_sum[15];
        next_flags[`AALM_FLAG_Z] = (word_sum == 16'h0000);
        next_flags[`AALM_FLAG_S] = word_sum[15] ^ (~pair_val[15] & word_sum[15]);
        flag_mask = `AALM_MASK_ZCNVS;
      end
      aalm_pkg::OP_WORD_MINUS_IMMEDIATE:
      begin
        long_op = 1'b1;
        res16 = word_dif; // RQ6
        next_flags[`AALM_FLAG_V] = pair_val[15] & ~word_dif[15];
        next_flags[`AALM_FLAG_C] = word_dif[15] & ~pair_val[15];
        next_flags[`AALM_FLAG_N] = word_dif[15];
        next_flags[`AALM_FLAG_Z] = (word_dif == 16'h0000);
        next_flags[`AALM_FLAG_S] = word_dif[15] ^ (pair_val[15] & ~word_dif[15]);
        flag_mask = `AALM_MASK_ZCNVS;
      end
      aalm_pkg::OP_UNSIGNED_PRODUCT,
      aalm_pkg::OP_SIGNED_PRODUCT,
      aalm_pkg::OP_MIXED_SIGN_PRODUCT,
      aalm_pkg::OP_FRACTIONAL_UNSIGNED_PRODUCT,
      aalm_pkg::OP_FRACTIONAL_SIGNED_PRODUCT,
      aalm_pkg::OP_FRACTIONAL_MIXED_PRODUCT:
      begin
        long_op = 1'b1;
        res16 = mul_res; // RQ12
        long_lo = `AALM_PROD_LO_IDX;
        long_hi = `AALM_PROD_HI_IDX;
        next_flags[`AALM_FLAG_C] = mul_raw[15];
        next_flags[`AALM_FLAG_Z] = (mul_res == 16'h0000);
        flag_mask = `AALM_MASK_ZC;
      end
      default:
      begin
        // unused codes write the operand back, so register and flags stay put
        arith[7:0] = op_a;
      end
    endcase
    if (!long_op && cmd_i.op != aalm_pkg::OP_NONE)
    begin
      write8 = 1'b1;
      res8 = arith[7:0];
      next_flags = (flag_mask == `AALM_MASK_ZNV) ? f_logic_flags(arith[7:0])
                 : f_arith_flags(arith);
      if (cmd_i.op == aalm_pkg::OP_PLUS_ONE || cmd_i.op == aalm_pkg::OP_MINUS_ONE)
      begin
        next_flags[`AALM_FLAG_V] = arith[8];
      end
    end
  end

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------

  wire logic apb_hit_gpr = (apb_i.paddr <= `AALM_GPR_LAST) && (apb_i.paddr[1:0] == 2'b00);
  wire logic apb_hit_status = (apb_i.paddr == `AALM_STATUS_OFS);
  wire logic [4:0] apb_idx = apb_i.paddr[6:2];
  // software waits while the datapath owns the register file this edge
  wire logic apb_go = apb_i.psel & apb_i.penable & ~apb_pready_o & ~cmd_take & ~commit_long;
  wire logic apb_wr_gpr = apb_go & apb_i.pwrite & apb_hit_gpr;
  wire logic apb_wr_status = apb_go & apb_i.pwrite & apb_hit_status;
  wire logic [7:0] apb_rd_byte = apb_hit_gpr ? gpr[apb_idx]
                               : apb_hit_status ? sreg : 8'h00;

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state <= aalm_pkg::ST_IDLE;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end
    else
    begin
      busy_o <= cmd_take & long_op;
      done_o <= (cmd_take & ~long_op) | commit_long;
      case (state)
        aalm_pkg::ST_IDLE:
        begin
          if (cmd_take && long_op)
          begin
            state <= aalm_pkg::ST_SECOND; // RQ5 RQ6 RQ12
          end
        end
        aalm_pkg::ST_SECOND:
        begin
          state <= aalm_pkg::ST_IDLE;
        end
        default:
        begin
          state <= aalm_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      hold_res <= 16'h0000;
      hold_flags <= 8'h00;
      hold_mask <= `AALM_MASK_NONE;
      hold_lo <= 5'h00;
      hold_hi <= 5'h00;
    end
    else if (cmd_take)
    begin
      hold_res <= res16;
      hold_flags <= next_flags;
      hold_mask <= flag_mask;
      hold_lo <= long_lo;
      hold_hi <= long_hi;
    end
  end

  // ---------------------------------------------------------------
  // register file and status
  // ---------------------------------------------------------------

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      for (int i = 0; i < 32; i++)
      begin
        gpr[i] <= `AALM_GPR_RST;
      end
    end
    else if (commit_long)
    begin
      gpr[hold_lo] <= hold_res[7:0];
      gpr[hold_hi] <= hold_res[15:8];
    end
    else if (cmd_take && write8)
    begin
      gpr[cmd_i.rd] <= res8;
    end
    else if (apb_wr_gpr)
    begin
      gpr[apb_idx] <= apb_i.pwdata[7:0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      sreg <= `AALM_STATUS_RST;
    end
    else if (commit_long)
    begin
      sreg <= f_merge(sreg, hold_flags, hold_mask); // RQ16
    end
    else if (cmd_take)
    begin
      sreg <= f_merge(sreg, next_flags, flag_mask); // RQ16
    end
    else if (apb_wr_status)
    begin
      sreg <= apb_i.pwdata[7:0];
    end
  end

  assign status_o = sreg;

  // ---------------------------------------------------------------
  // apb answer
  // ---------------------------------------------------------------

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      apb_pready_o <= 1'b0;
      apb_prdata_o <= 32'h00000000;
      apb_pslverr_o <= 1'b0;
    end
    else
    begin
      apb_pready_o <= apb_go;
      apb_pslverr_o <= apb_go & ~apb_hit_gpr & ~apb_hit_status;
      if (apb_go && !apb_i.pwrite)
      begin
        apb_prdata_o <= {24'h000000, apb_rd_byte};
      end
    end
  end

endmodule
`default_nettype wire

// ### bench/aalm_core_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module aalm_core_asserts
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic cmd_valid_i,
  input wire aalm_pkg::aalm_cmd_type cmd_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic [7:0] status_o
);
  // --------
  // command decode
  // --------
  wire logic take = cmd_valid_i && !busy_o;
  wire logic [4:0] op = cmd_i.op;
  wire logic word = take && (op == 5'h07 || op == 5'h08);
  wire logic prod = take && op >= 5'h17 && op <= 5'h1C;
  wire logic arith = take && op >= 5'h01 && op <= 5'h06;
  // the two inverts touch carry, so they are left out of the znv group
  wire logic znv = take && op >= 5'h09 && op <= 5'h15 && op != 5'h0E && op != 5'h0F;
  wire logic vclr = znv && op != 5'h12 && op != 5'h13;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  // --------
  // checks
  // --------
  a_single_done: assert property (take && !word && !prod |=> done_o && !busy_o)
    else $error("one-cycle command late");
  a_word_timing: assert property (word |=> busy_o && !done_o ##1 done_o && !busy_o)
    else $error("word command timing wrong");
  a_word_sign: assert property (word |-> ##2 status_o[4] == (status_o[2] ^ status_o[3]))
    else $error("word sign flag wrong");
  a_prod_keep: assert property (prod |=> busy_o ##1
    done_o && status_o[7:2] == $past(status_o[7:2], 2))
    else $error("product timing or flags wrong");
  a_arith_keep_s: assert property (arith |=> status_o[4] == $past(status_o[4]))
    else $error("sign flag changed by byte arithmetic");
  a_znv_keep: assert property (znv |=> status_o[5:4] == $past(status_o[5:4])
    && status_o[0] == $past(status_o[0]))
    else $error("unlisted flag changed");
  a_logic_v_clear: assert property (vclr |=> !status_o[3])
    else $error("overflow not cleared by logic op");
  a_ones_invert: assert property (take && op == 5'h0E |=> status_o[0] && !status_o[3]
    && status_o[5] == $past(status_o[5]))
    else $error("ones invert flags wrong");
  a_twos_carry: assert property (take && op == 5'h0F |=> status_o[0] == !status_o[1])
    else $error("twos invert carry wrong");
  a_set_no_flags: assert property (take && op == 5'h16 |=> $stable(status_o))
    else $error("all ones changed flags");
endmodule

bind aalm_core aalm_core_asserts u_aalm_core_asserts
(
  .clk_i(clk_i),
  .sys_rst_i(sys_rst_i),
  .cmd_valid_i(cmd_valid_i),
  .cmd_i(cmd_i),
  .busy_o(busy_o),
  .done_o(done_o),
  .status_o(status_o)
);
`default_nettype wire

// ### bench/aalm_decoder_model.sv
`timescale 1ns/1ps
`default_nettype none
// stand-in for the instruction decoder: holds a command until the datapath takes it
module aalm_decoder_model
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic issue_i,
  input wire aalm_pkg::aalm_cmd_type next_cmd_i,
  input wire logic busy_i,
  output logic cmd_valid_o,
  output aalm_pkg::aalm_cmd_type cmd_o
);
  // --------
  // command holding
  // --------
  logic valid = 1'b0;
  aalm_pkg::aalm_cmd_type held = '0;
  wire logic taken = valid && !busy_i;
  assign cmd_valid_o = valid;
  // fields flip when idle so a stale command is never read as a live one
  assign cmd_o = valid ? held : aalm_pkg::aalm_cmd_type'(~held);

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      valid <= 1'b0;
    else if (issue_i)
      valid <= 1'b1;
    else if (taken)
      valid <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (issue_i)
      held <= next_cmd_i;
  end
endmodule
`default_nettype wire

// ### bench/alu_arith_logic_multiply_test.sv
`timescale 1ns/1ps
`default_nettype none
module alu_arith_logic_multiply_test;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic issue = 1'b0;
  logic slverr = 1'b0;
  aalm_pkg::aalm_cmd_type next_cmd = '0;
  aalm_pkg::aalm_cmd_type cmd;
  aalm_pkg::aalm_apb_req_type apb_req = '0;
  logic cmd_valid;
  logic busy;
  logic done;
  logic pready;
  logic pslverr;
  logic [7:0] status;
  logic [31:0] prdata;
  logic [31:0] q;
  int error_cnt = 0;
  int tests_run = 0;

  initial forever #4 clk_i = ~clk_i;

  aalm_decoder_model u_aalm_decoder_model
  (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .issue_i(issue),
    .next_cmd_i(next_cmd),
    .busy_i(busy),
    .cmd_valid_o(cmd_valid),
    .cmd_o(cmd)
  );

  aalm_core u_aalm_core
  (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .cmd_valid_i(cmd_valid),
    .cmd_i(cmd),
    .apb_i(apb_req),
    .busy_o(busy),
    .done_o(done),
    .status_o(status),
    .apb_pready_o(pready),
    .apb_prdata_o(prdata),
    .apb_pslverr_o(pslverr)
  );

  // --------
  // tasks
  // --------
  task automatic print_verdict();
    if (error_cnt == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic stall(input string n);
    error_cnt++;
    $display("CHECK FAILED %s expected handshake seen timeout", n);
    print_verdict();
  endtask

  // request held until pready is sampled high; the slave may stall while commands run
  task automatic apb_xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    apb_req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: {24'h000000, d}};
    @(posedge clk_i);
    apb_req.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (pready !== 1'b1 && n < 64);
    if (n >= 64) stall("apb ready");
    q = prdata;
    slverr = pslverr;
    apb_req <= '0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string n);
    apb_xfer(1'b0, a, 8'h00);
    chk(n, {24'h000000, e}, q);
    chk("mapped error", 32'h00000000, {31'h0000000, slverr});
  endtask

  task automatic cmd_run(input logic [4:0] op, input logic [4:0] rd, input logic [7:0] b,
                         input int k);
    int n;
    next_cmd <= '{op: aalm_pkg::aalm_op_type'(op), rd: rd, source_register: rd + 5'h01,
                  imm: b};
    issue <= 1'b1;
    repeat (k) @(posedge clk_i);
    issue <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (done !== 1'b1 && n < 16);
    if (n >= 16) stall("command done");
  endtask

  // operand b is both the second register and the immediate; word ops use pair 25:24
  task automatic row(input logic [4:0] op, input logic [7:0] a, b, s0, elo, ehi, est);
    logic [4:0] rd;
    logic [4:0] d;
    rd = (op == 5'h07 || op == 5'h08) ? 5'h18 : 5'h10;
    d = (op >= 5'h17) ? 5'h00 : rd;
    apb_xfer(1'b1, {1'b0, rd, 2'b00}, a);
    apb_xfer(1'b1, {1'b0, rd + 5'h01, 2'b00}, b);
    apb_xfer(1'b1, 8'h80, s0);
    cmd_run(op, rd, b, 1);
    rdchk({1'b0, d, 2'b00}, elo, "result low");
    rdchk({1'b0, d + 5'h01, 2'b00}, ehi, "result high");
    rdchk(8'h80, est, "status register");
    chk("status port", {24'h000000, est}, {24'h000000, status});
  endtask

  // --------
  // sequence
  // --------
  initial
  begin
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rdchk(8'h7C, 8'h00, "register reset");
    rdchk(8'h80, 8'h00, "status reset");
    apb_xfer(1'b0, 8'h84, 8'h00);
    chk("unmapped error", 32'h00000001, {31'h0000000, slverr});
    chk("unmapped data", 32'h00000000, q);
    apb_xfer(1'b1, 8'h42, 8'h55);
    chk("misaligned error", 32'h00000001, {31'h0000000, slverr});
    rdchk(8'h40, 8'h00, "refused write");
    row(5'h01, 8'h7F, 8'h01, 8'h00, 8'h80, 8'h01, 8'h2C);
    row(5'h02, 8'hFF, 8'h00, 8'h01, 8'h00, 8'h00, 8'h23);
    row(5'h03, 8'h10, 8'h20, 8'h10, 8'hF0, 8'h20, 8'h15);
    row(5'h04, 8'h00, 8'h00, 8'h01, 8'hFF, 8'h00, 8'h25);
    row(5'h05, 8'h80, 8'h01, 8'h00, 8'h7F, 8'h01, 8'h28);
    row(5'h06, 8'h05, 8'h04, 8'h01, 8'h00, 8'h04, 8'h02);
    row(5'h07, 8'h81, 8'h7F, 8'h20, 8'h00, 8'h80, 8'h2C);
    row(5'h08, 8'h00, 8'h80, 8'h00, 8'h80, 8'h7F, 8'h18);
    row(5'h09, 8'hF0, 8'h3C, 8'h29, 8'h30, 8'h3C, 8'h21);
    row(5'h0A, 8'h0F, 8'hF0, 8'h00, 8'h00, 8'hF0, 8'h02);
    row(5'h0B, 8'h80, 8'h01, 8'h08, 8'h81, 8'h01, 8'h04);
    row(5'h0C, 8'h00, 8'h00, 8'h3D, 8'h00, 8'h00, 8'h33);
    row(5'h0D, 8'hAA, 8'hAA, 8'h00, 8'h00, 8'hAA, 8'h02);
    row(5'h0E, 8'h0F, 8'h00, 8'h20, 8'hF0, 8'h00, 8'h25);
    row(5'h0F, 8'h80, 8'h00, 8'h00, 8'h80, 8'h00, 8'h0D);
    row(5'h10, 8'h01, 8'h80, 8'h08, 8'h81, 8'h80, 8'h04);
    row(5'h11, 8'hFF, 8'h0F, 8'h00, 8'hF0, 8'h0F, 8'h04);
    row(5'h12, 8'h7F, 8'h00, 8'h01, 8'h80, 8'h00, 8'h0D);
    row(5'h13, 8'h80, 8'h00, 8'h00, 8'h7F, 8'h00, 8'h08);
    row(5'h14, 8'h80, 8'h00, 8'h02, 8'h80, 8'h00, 8'h04);
    row(5'h15, 8'h55, 8'h00, 8'h01, 8'h00, 8'h00, 8'h03);
    row(5'h16, 8'h00, 8'h00, 8'h2A, 8'hFF, 8'h00, 8'h2A);
    row(5'h17, 8'hFF, 8'hFF, 8'h0C, 8'h01, 8'hFE, 8'h0D);
    row(5'h18, 8'hFF, 8'h80, 8'h00, 8'h80, 8'h00, 8'h00);
    row(5'h19, 8'hFF, 8'h80, 8'h00, 8'h80, 8'hFF, 8'h01);
    row(5'h1A, 8'h80, 8'h80, 8'h00, 8'h00, 8'h80, 8'h00);
    row(5'h1B, 8'hC0, 8'h40, 8'h00, 8'h00, 8'hE0, 8'h01);
    row(5'h1C, 8'hC0, 8'hC0, 8'h00, 8'h00, 8'hA0, 8'h01);
    apb_xfer(1'b1, 8'h40, 8'h7E);
    apb_xfer(1'b1, 8'h80, 8'h00);
    cmd_run(5'h12, 5'h10, 8'h00, 2);
    rdchk(8'h40, 8'h80, "back to back result");
    rdchk(8'h80, 8'h0C, "back to back status");
    cmd_run(5'h1D, 5'h10, 8'h00, 1);
    rdchk(8'h40, 8'h80, "unused op result");
    rdchk(8'h80, 8'h0C, "unused op status");
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rdchk(8'h40, 8'h00, "register after reset");
    rdchk(8'h80, 8'h00, "status after reset");
    chk("busy after reset", 32'h00000000, {31'h0000000, busy});
    print_verdict();
  end
endmodule
`default_nettype wire
